// >>> rtl/wsp_pkg.sv
// Operation
// - Wait halts base clock; watchdog may continue.
// - Stop bit gates peripheral clocks in wait.
// - Sub and main-sourced divided clocks keep running.
// - Wait holds ports and analog outputs.
// - Clock output behaviour in wait mode.
// - Stop mode pin states defined.
// - Wait exits on reset, NMI, peripheral.
// - Gated peripherals cannot wake device.
// - Wake keeps pre-sleep clock selection.
// - Timer wake depends on count source.
// - Serial wake depends on clock source.
// - Always-on sources wake in any gating setting, with the enable flag set.
// - Stop halts all unprotected clocks.
package wsp_pkg;

    // -------------------------------------------------------------------
    // Widths and encodings.
    // -------------------------------------------------------------------
    localparam int WSP_PORT_W = 16;
    localparam int WSP_DA_W = 8;
    localparam int WSP_LVL_W = 3;
    localparam int WSP_NSRC = 8;
    localparam logic [1:0] WSP_CKO_PORT = 2'h0;
    localparam logic [1:0] WSP_CKO_LOW = 2'h1;
    localparam logic [1:0] WSP_CKO_DIV8 = 2'h2;
    localparam logic [1:0] WSP_CKO_DIV32 = 2'h3;
    localparam logic [2:0] WSP_LVL_OFF = 3'h0;

    // Power state, one-hot.
    typedef enum logic [2:0] {
        WSP_RUN = 3'b001,
        WSP_WAIT = 3'b010,
        WSP_STOP = 3'b100
    } wsp_state_e;

    // Wake source descriptor: level and whether its clock survives gating.
    typedef struct packed {
        logic req;
        logic [WSP_LVL_W-1:0] level;
        logic indep_clk;
    } wsp_src_s;

    // Clock enables handed to the clock tree.
    typedef struct packed {
        logic base;
        logic wdt;
        logic div1;
        logic div8;
        logic div32;
        logic prog_div;
        logic conv;
        logic sub32;
    } wsp_clken_s;

endpackage

// >>> rtl/wsp_power_ctrl.sv
`timescale 1ns/1ps
module wsp_power_ctrl
    import wsp_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_wait_instr,
    input wire logic i_stop_instr,
    input wire logic i_periph_clk_stop_in_wait,
    input wire logic i_wdt_on_chip_osc,
    input wire logic i_prog_div_main_src,
    input wire logic [1:0] i_clock_out_pin_sel,
    input wire logic i_low_clk,
    input wire logic i_div8_clk,
    input wire logic i_div32_clk,
    input wire logic i_irq_enable_flag,
    input wire logic [WSP_LVL_W-1:0] i_processor_priority_level,
    input wire logic i_nmi,
    input wire logic i_always_on_irq,
    input wire wsp_src_s [WSP_NSRC-1:0] i_src,
    input wire logic [WSP_PORT_W-1:0] i_port_out,
    input wire logic [WSP_DA_W-1:0] i_analog_out_0,
    input wire logic [WSP_DA_W-1:0] i_analog_out_1,
    output wsp_clken_s o_clken,
    output logic [2:0] o_state,
    output logic o_wake,
    output logic [WSP_PORT_W-1:0] o_port_pins,
    output logic [WSP_DA_W-1:0] o_analog_out_0,
    output logic [WSP_DA_W-1:0] o_analog_out_1,
    output logic o_clock_out_pin,
    output logic o_main_xtal_out,
    output logic o_main_xtal_in_oe,
    output logic o_sub_xtal_oe
);

    // -------------------------------------------------------------------
    // Wake qualification.
    // -------------------------------------------------------------------
    wsp_state_e state_r;
    logic gate_periph;
    logic src_wake;
    logic wake_req;

    // Peripheral clock gating only applies inside wait with the stop bit set.
    assign gate_periph = (state_r == WSP_WAIT) && i_periph_clk_stop_in_wait;

    // A source wakes only with a level above the processor level and the enable flag.
    always_comb begin
        src_wake = 1'b0;
        for (int k = 0; k < WSP_NSRC; k++) begin
            if (i_src[k].req && i_src[k].level != WSP_LVL_OFF
                && i_src[k].level > i_processor_priority_level
                && (!gate_periph || i_src[k].indep_clk)) begin
                src_wake = 1'b1;
            end
        end
    end

    // NMI and always-on lines ignore the gating bit; the enable flag masks always-on but not NMI.
    assign wake_req = i_nmi || ((i_always_on_irq || src_wake) && i_irq_enable_flag);

    // -------------------------------------------------------------------
    // Power state machine.
    // -------------------------------------------------------------------
    // Reset returns to run; the clock selection is untouched so a wake resumes on it.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r <= WSP_RUN;
        end else begin
            unique case (state_r)
                WSP_RUN: begin
                    if (i_stop_instr) begin
                        state_r <= WSP_STOP;
                    end else if (i_wait_instr) begin
                        state_r <= WSP_WAIT;
                    end
                end
                WSP_WAIT, WSP_STOP: begin
                    if (wake_req) begin
                        state_r <= WSP_RUN;
                    end
                end
                default: begin
                    state_r <= WSP_RUN;
                end
            endcase
        end
    end

    // One-cycle wake pulse and state view.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_wake <= 1'b0;
            o_state <= WSP_RUN;
        end else begin
            o_wake <= (state_r != WSP_RUN) && wake_req;
            o_state <= state_r;
        end
    end

    // -------------------------------------------------------------------
    // Clock enables.
    // -------------------------------------------------------------------
    // Enables are registered so every output comes from a flip-flop; one cycle lag.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_clken <= '1;
        end else begin
            unique case (state_r)
                WSP_RUN: begin
                    o_clken <= '1;
                end
                WSP_WAIT: begin
                    o_clken.base <= 1'b0;
                    o_clken.wdt <= i_wdt_on_chip_osc;
                    o_clken.div1 <= !i_periph_clk_stop_in_wait;
                    o_clken.div8 <= !i_periph_clk_stop_in_wait;
                    o_clken.div32 <= !i_periph_clk_stop_in_wait;
                    o_clken.conv <= !i_periph_clk_stop_in_wait;
                    o_clken.prog_div <= i_prog_div_main_src || !i_periph_clk_stop_in_wait;
                    o_clken.sub32 <= 1'b1;
                end
                default: begin
                    o_clken <= '0;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Pin holding.
    // -------------------------------------------------------------------
    // Ports and analog outputs follow in run and freeze on sleep entry.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_port_pins <= '0;
            o_analog_out_0 <= '0;
            o_analog_out_1 <= '0;
        end else if (state_r == WSP_RUN) begin
            o_port_pins <= i_port_out;
            o_analog_out_0 <= i_analog_out_0;
            o_analog_out_1 <= i_analog_out_1;
        end
    end

    // Clock output pin; port mode shows the port's low bit.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_clock_out_pin <= 1'b0;
        end else begin
            unique case (i_clock_out_pin_sel)
                WSP_CKO_LOW: begin
                    if (state_r == WSP_STOP) begin
                        o_clock_out_pin <= 1'b1;
                    end else begin
                        o_clock_out_pin <= i_low_clk;
                    end
                end
                WSP_CKO_DIV8: begin
                    if (state_r == WSP_RUN || (state_r == WSP_WAIT && !i_periph_clk_stop_in_wait)) begin
                        o_clock_out_pin <= i_div8_clk;
                    end
                end
                WSP_CKO_DIV32: begin
                    if (state_r == WSP_RUN || (state_r == WSP_WAIT && !i_periph_clk_stop_in_wait)) begin
                        o_clock_out_pin <= i_div32_clk;
                    end
                end
                default: begin
                    if (state_r == WSP_RUN) begin
                        o_clock_out_pin <= i_port_out[0];
                    end
                end
            endcase
        end
    end

    // Crystal pins: stop floats the inputs and the sub output, drives main out high.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_main_xtal_out <= 1'b0;
            o_main_xtal_in_oe <= 1'b0;
            o_sub_xtal_oe <= 1'b1;
        end else begin
            o_main_xtal_out <= (state_r == WSP_STOP);
            o_main_xtal_in_oe <= 1'b0;
            o_sub_xtal_oe <= (state_r != WSP_STOP);
        end
    end

    // -------------------------------------------------------------------
    // Checks.
    // -------------------------------------------------------------------
    // Any requesting source whose clock survives the gating; lets the gating check watch every slot.
    logic indep_req;
    always_comb begin
        indep_req = 1'b0;
        for (int k = 0; k < WSP_NSRC; k++) begin
            if (i_src[k].req && i_src[k].indep_clk) begin
                indep_req = 1'b1;
            end
        end
    end

    a_wait_base_off: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        state_r == WSP_WAIT |=> !o_clken.base) else $error("base clock runs in wait");
    a_wait_gate_div1: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        state_r == WSP_WAIT && i_periph_clk_stop_in_wait |=> !o_clken.div1) else $error("div1 not gated");
    a_wait_sub_on: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        state_r == WSP_WAIT |=> o_clken.sub32) else $error("sub clock stopped in wait");
    a_hold_ports: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        state_r != WSP_RUN && $past(state_r) != WSP_RUN |=> $stable(o_port_pins))
        else $error("ports moved while asleep");
    a_stop_clock_out_pin_high: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        state_r == WSP_STOP && i_clock_out_pin_sel == WSP_CKO_LOW |=> o_clock_out_pin) else $error("clock out not high");
    a_stop_all_off: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        state_r == WSP_STOP |=> o_clken == '0) else $error("clock alive in stop");
    a_nmi_wakes: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        state_r == WSP_WAIT && i_nmi |=> state_r == WSP_RUN ##0 o_wake) else $error("nmi did not wake");
    a_low_level_no_wake: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        state_r == WSP_WAIT && !i_nmi && !i_always_on_irq && !src_wake |=> state_r == WSP_WAIT)
        else $error("spurious wake");
    a_gated_no_wake: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        gate_periph && !i_nmi && !i_always_on_irq && !indep_req |=> state_r == WSP_WAIT)
        else $error("gated source woke");

    c_wait_wake: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
        state_r == WSP_WAIT ##1 state_r == WSP_RUN);
    c_stop_wake: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
        state_r == WSP_STOP ##1 state_r == WSP_RUN);
    c_gated_wait: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) gate_periph && src_wake);

endmodule

// >>> sim/test_wait_stop_power_mode_control.sv
`timescale 1ns/1ps
module test_wait_stop_power_mode_control
    import wsp_pkg::*;
;
    // ------------------------------------------------------------------
    // Stimulus table and comparison macro.
    // ------------------------------------------------------------------
    // One wake case: gating bit, clock independence, flag, levels, requester, outcome.
    typedef struct packed {
        logic stopb;
        logic ind;
        logic flag;
        logic [2:0] lvl;
        logic [2:0] ppl;
        logic req;
        logic nmi;
        logic aon;
        logic exp;
    } wsp_row_s;
    `define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin fail_count++; \
        $display("unexpected %s: expected %0h seen %0h", nm, ex, gt); end end
    localparam wsp_row_s ROWS [9] = '{
        '{1'b0, 1'b0, 1'b1, 3'h3, 3'h2, 1'b1, 1'b0, 1'b0, 1'b1},
        '{1'b0, 1'b0, 1'b1, 3'h2, 3'h2, 1'b1, 1'b0, 1'b0, 1'b0},
        '{1'b0, 1'b0, 1'b1, 3'h0, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0},
        '{1'b0, 1'b0, 1'b0, 3'h3, 3'h2, 1'b1, 1'b0, 1'b0, 1'b0},
        '{1'b1, 1'b0, 1'b1, 3'h3, 3'h2, 1'b1, 1'b0, 1'b0, 1'b0},
        '{1'b1, 1'b1, 1'b1, 3'h3, 3'h2, 1'b1, 1'b0, 1'b0, 1'b1},
        '{1'b1, 1'b0, 1'b0, 3'h0, 3'h7, 1'b0, 1'b1, 1'b0, 1'b1},
        '{1'b1, 1'b0, 1'b1, 3'h0, 3'h0, 1'b0, 1'b0, 1'b1, 1'b1},
        '{1'b0, 1'b0, 1'b1, 3'h7, 3'h6, 1'b1, 1'b0, 1'b0, 1'b1}
    };

    logic i_ref_clk, i_resetn, i_wait_instr, i_stop_instr, i_periph_clk_stop_in_wait;
    logic i_wdt_on_chip_osc, i_prog_div_main_src;
    // The slow clocks have one driver only, the toggling process below.
    logic i_low_clk = 1'b0;
    logic i_div8_clk = 1'b0;
    logic i_div32_clk = 1'b0;
    logic i_irq_enable_flag, i_nmi, i_always_on_irq, o_wake, o_clock_out_pin;
    logic o_main_xtal_out, o_main_xtal_in_oe, o_sub_xtal_oe, seen;
    logic [1:0] i_clock_out_pin_sel;
    logic [2:0] i_processor_priority_level, o_state;
    wsp_src_s [WSP_NSRC-1:0] i_src;
    logic [WSP_PORT_W-1:0] i_port_out, o_port_pins;
    logic [WSP_DA_W-1:0] i_analog_out_0, i_analog_out_1, o_analog_out_0, o_analog_out_1;
    wsp_clken_s o_clken;
    int fail_count = 0;
    int n_checks = 0;

    wsp_power_ctrl DUT (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_wait_instr(i_wait_instr),
        .i_stop_instr(i_stop_instr), .i_periph_clk_stop_in_wait(i_periph_clk_stop_in_wait),
        .i_wdt_on_chip_osc(i_wdt_on_chip_osc), .i_prog_div_main_src(i_prog_div_main_src),
        .i_clock_out_pin_sel(i_clock_out_pin_sel), .i_low_clk(i_low_clk), .i_div8_clk(i_div8_clk),
        .i_div32_clk(i_div32_clk), .i_irq_enable_flag(i_irq_enable_flag),
        .i_processor_priority_level(i_processor_priority_level), .i_nmi(i_nmi),
        .i_always_on_irq(i_always_on_irq), .i_src(i_src), .i_port_out(i_port_out),
        .i_analog_out_0(i_analog_out_0), .i_analog_out_1(i_analog_out_1), .o_clken(o_clken),
        .o_state(o_state), .o_wake(o_wake), .o_port_pins(o_port_pins), .o_analog_out_0(o_analog_out_0),
        .o_analog_out_1(o_analog_out_1), .o_clock_out_pin(o_clock_out_pin),
        .o_main_xtal_out(o_main_xtal_out), .o_main_xtal_in_oe(o_main_xtal_in_oe),
        .o_sub_xtal_oe(o_sub_xtal_oe));

    // ------------------------------------------------------------------
    // Clocks and helpers.
    // ------------------------------------------------------------------
    // The 20 MHz reference clock.
    initial begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end

    // Slow clocks are sampled as data, so toggling them every edge shows any freeze at once.
    always @(posedge i_ref_clk) begin
        i_low_clk <= ~i_low_clk;
        i_div8_clk <= ~i_div8_clk;
        i_div32_clk <= ~i_div32_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask

    // Pulses an instruction for one edge; returns at the edge where the state has moved.
    task automatic enter(input logic stp, input logic wt);
        cyc(1);
        i_stop_instr <= stp;
        i_wait_instr <= wt;
        cyc(1);
        i_stop_instr <= 1'b0;
        i_wait_instr <= 1'b0;
    endtask

    // The NMI is a level, so it is dropped once the wake has been taken.
    task automatic nmi_wake;
        cyc(1);
        i_nmi <= 1'b1;
        cyc(1);
        i_nmi <= 1'b0;
        cyc(3);
    endtask

    task automatic results;
        if (fail_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // A hang costs one mismatch; the whole run needs under 200 cycles.
    initial begin
        #(5000 * 50);
        fail_count++;
        results();
    end

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        {i_resetn, i_wait_instr, i_stop_instr, i_periph_clk_stop_in_wait, i_wdt_on_chip_osc} = '0;
        {i_prog_div_main_src, i_clock_out_pin_sel} = '0;
        {i_irq_enable_flag, i_processor_priority_level, i_nmi, i_always_on_irq, i_src} = '0;
        {i_port_out, i_analog_out_0, i_analog_out_1} = '0;
        cyc(2);
        #1;
        `CHK("rst state", WSP_RUN, o_state)
        `CHK("rst clken", 8'hff, o_clken)
        `CHK("rst sub oe", 1'b1, o_sub_xtal_oe)
        cyc(2);
        i_resetn <= 1'b1;
        // Table of wake decisions taken from wait mode.
        foreach (ROWS[r]) begin
            cyc(1);
            i_periph_clk_stop_in_wait <= ROWS[r].stopb;
            i_wdt_on_chip_osc <= ~ROWS[r].stopb;
            i_prog_div_main_src <= ROWS[r].ind;
            i_irq_enable_flag <= ROWS[r].flag;
            i_processor_priority_level <= ROWS[r].ppl;
            i_src[2] <= '{1'b0, ROWS[r].lvl, ROWS[r].ind};
            i_port_out <= 16'h1234 + 16'(r);
            i_analog_out_0 <= 8'h5a;
            enter(1'b0, 1'b1);
            i_port_out <= 16'hbeef;
            i_analog_out_0 <= 8'ha5;
            i_analog_out_1 <= 8'h3c;
            cyc(1);
            i_src[2].req <= ROWS[r].req;
            i_nmi <= ROWS[r].nmi;
            i_always_on_irq <= ROWS[r].aon;
            #1;
            `CHK("wait state", WSP_WAIT, o_state)
            `CHK("base", 1'b0, o_clken.base)
            `CHK("wdt", ~ROWS[r].stopb, o_clken.wdt)
            `CHK("div1", ~ROWS[r].stopb, o_clken.div1)
            `CHK("div32", ~ROWS[r].stopb, o_clken.div32)
            `CHK("conv", ~ROWS[r].stopb, o_clken.conv)
            `CHK("prog div", ~ROWS[r].stopb | ROWS[r].ind, o_clken.prog_div)
            `CHK("sub32", 1'b1, o_clken.sub32)
            `CHK("port hold", 16'h1234 + 16'(r), o_port_pins)
            `CHK("da0 hold", 8'h5a, o_analog_out_0)
            cyc(1);
            {i_src[2].req, i_nmi, i_always_on_irq} <= '0;
            #1;
            // The wake pulse rises at the edge that leaves wait; the state view follows one edge later.
            `CHK("wake", ROWS[r].exp, o_wake)
            cyc(1);
            #1;
            `CHK("after", ROWS[r].exp ? WSP_RUN : WSP_WAIT, o_state)
            `CHK("wake pulse", 1'b0, o_wake)
            if (ROWS[r].exp) `CHK("port live", 16'hbeef, o_port_pins)
            else nmi_wake();
        end
        // Clock output in wait: low speed runs on, divided clocks run only with the gating bit clear.
        for (int s = 1; s < 4; s++) begin
            for (int g = 0; g < 2; g++) begin
                cyc(1);
                i_periph_clk_stop_in_wait <= g[0];
                i_clock_out_pin_sel <= 2'(s);
                enter(1'b0, 1'b1);
                cyc(2);
                #1;
                seen = o_clock_out_pin;
                cyc(1);
                #1;
                `CHK("clock_out_pin", (s == 1 || g == 0) ? ~seen : seen, o_clock_out_pin)
                nmi_wake();
            end
        end
        // Both instructions at once: stop wins; pins take their stop levels.
        cyc(1);
        i_clock_out_pin_sel <= WSP_CKO_LOW;
        i_port_out <= 16'h0f0f;
        enter(1'b1, 1'b1);
        i_port_out <= 16'hf0f0;
        cyc(2);
        i_always_on_irq <= 1'b1;
        #1;
        `CHK("stop state", WSP_STOP, o_state)
        `CHK("stop clk", 4'h0, {o_clken.base, o_clken.div1, o_clken.div8, o_clken.conv})
        `CHK("stop pins", 4'hc, {o_clock_out_pin, o_main_xtal_out, o_main_xtal_in_oe, o_sub_xtal_oe})
        `CHK("stop port", 16'h0f0f, o_port_pins)
        cyc(1);
        i_always_on_irq <= 1'b0;
        #1;
        `CHK("stop wake", 1'b1, o_wake)
        cyc(1);
        #1;
        `CHK("stop run", WSP_RUN, o_state)
        // Hardware reset in mid-run: a sleeping part comes back in run with every clock enabled.
        enter(1'b0, 1'b1);
        cyc(1);
        #1;
        `CHK("pre rst", WSP_WAIT, o_state)
        cyc(1);
        i_resetn <= 1'b0;
        #1;
        `CHK("rst wake", WSP_RUN, o_state)
        `CHK("rst clk", 8'hff, o_clken)
        cyc(1);
        i_resetn <= 1'b1;
        cyc(2);
        results();
    end
endmodule
